// [hdl/dcs_core.sv]
// converter code, reference and startup control behind a serial link
// assumes scl/sda pins from outside, a nonvolatile store presenting words with a valid level
// Function
// R1 - the link runs at standard, fast and fast-plus rates, up to 1 Mbps, which the controller respects.
// R2 - bus operation commands turn the output on or off and move it to margin high or low.
// R3 - after reset every register, the output code included, is loaded from the nonvolatile words; the code loads all but on_q, which reset sets to on.
// R4 - the output comes up high impedance by default, or grounded through a resistor if so saved; the code loads any saved power-down value, active included.
// R5 - written codes are taken as unsigned straight binary.
// R6 - the supply is the reference unless the internal one is selected.
// R7 - the code is 8 or 10 bits wide and spans zero to two to the width minus one.
// R8 - a new code reaches the output only when the write frame ends.
// R9 - the internal reference is off after reset until software enables it; the code loads it from the nonvolatile config word.
// R10 - the power-up output state holds until the power-down field is written.
`timescale 1ns/1ps
`default_nettype none
module dcs_core #(
  parameter int unsigned RES = 10
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // serial link pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // nonvolatile words
  input wire logic nvm_valid,
  input wire logic [dcs_pkg::DCS_WORD_W-1:0] nvm_dac_data,
  input wire logic [dcs_pkg::DCS_WORD_W-1:0] nvm_config,
  input wire logic [dcs_pkg::DCS_WORD_W-1:0] nvm_margin_high,
  input wire logic [dcs_pkg::DCS_WORD_W-1:0] nvm_margin_low,
  // converter controls
  output logic [RES-1:0] dac_code,
  output logic [1:0] output_powerdown_select,
  output logic out_enable,
  output logic ref_internal_en,
  output logic [1:0] gain_span,
  output logic code_update,
  output logic nvm_loading
);
  import dcs_pkg::*;

  // pin synchronisers and edge history
  logic scl_s1_q, scl_s2_q, scl_p_q, sda_s1_q, sda_s2_q, sda_p_q;
  always_ff @(posedge mclk) begin
    scl_s1_q <= sys_rst ? 1'b1 : scl_in;
    scl_s2_q <= sys_rst ? 1'b1 : scl_s1_q;
    scl_p_q <= sys_rst ? 1'b1 : scl_s2_q;
    sda_s1_q <= sys_rst ? 1'b1 : sda_in;
    sda_s2_q <= sys_rst ? 1'b1 : sda_s1_q;
    sda_p_q <= sys_rst ? 1'b1 : sda_s2_q;
  end
  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_s2_q & ~scl_p_q; // R1
  assign scl_fall = ~scl_s2_q & scl_p_q;
  assign bus_start = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
  assign bus_stop = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;

  dcs_state_t st_q, st_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d, b2_q, b2_d, b3_q, b3_d;
  logic [3:0] cnt_q, cnt_d;
  logic [2:0] nb_q, nb_d;
  logic rw_q, rw_d, drv_q, drv_d, txi_q, txi_d;
  logic [RES-1:0] code_q, code_d;
  logic [7:0] mh_q, mh_d, ml_q, ml_d;
  logic [DCS_WORD_W-1:0] cfg_q, cfg_d;
  logic on_q, on_d, upd_q, upd_d;
  logic [DCS_WORD_W-1:0] rd_word, wr_word;
  logic [7:0] tx_byte;

  assign wr_word = {b2_q, b3_q};
  // read-back of the selected word
  always_comb begin
    case (ptr_q)
      DCS_CMD_DAC_DATA: rd_word = DCS_WORD_W'({code_q, {(DCS_CODE_MSB + 1 - RES){1'b0}}});
      DCS_CMD_MARGIN_HIGH: rd_word = DCS_WORD_W'({mh_q, {DCS_MARGIN_LSB{1'b0}}});
      DCS_CMD_MARGIN_LOW: rd_word = DCS_WORD_W'({ml_q, {DCS_MARGIN_LSB{1'b0}}});
      DCS_CMD_GEN_CONFIG: rd_word = cfg_q;
      DCS_CMD_OPERATION: rd_word = {8'h00, on_q ? DCS_OP_ON : DCS_OP_OFF};
      default: rd_word = 16'h0000;
    endcase
    tx_byte = txi_q ? rd_word[7:0] : rd_word[15:8];
  end

  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    b2_d = b2_q;
    b3_d = b3_q;
    cnt_d = cnt_q;
    nb_d = nb_q;
    rw_d = rw_q;
    drv_d = drv_q;
    txi_d = txi_q;
    code_d = code_q;
    mh_d = mh_q;
    ml_d = ml_q;
    cfg_d = cfg_q;
    on_d = on_q;
    upd_d = 1'b0;
    if (st_q == DCS_ST_LOAD) begin
      if (nvm_valid) begin
        code_d = nvm_dac_data[DCS_CODE_MSB -: RES]; // R3
        cfg_d = nvm_config; // R3 R4 R9
        mh_d = nvm_margin_high[DCS_CODE_MSB -: 8];
        ml_d = nvm_margin_low[DCS_CODE_MSB -: 8];
        st_d = DCS_ST_IDLE;
      end
    end else if (bus_start || bus_stop) begin
      // frame end commits the buffered write
      if (!rw_q && nb_q >= 3'd3) begin
        case (ptr_q)
          DCS_CMD_OPERATION: begin
            case (b2_q)
              DCS_OP_OFF: on_d = 1'b0; // R2
              DCS_OP_ON: on_d = 1'b1; // R2
              DCS_OP_MARGIN_HIGH: begin
                on_d = 1'b1;
                code_d = RES'({mh_q, {(RES - 8){1'b0}}}); // R2
                upd_d = 1'b1;
              end
              DCS_OP_MARGIN_LOW: begin
                on_d = 1'b1;
                code_d = RES'({ml_q, {(RES - 8){1'b0}}}); // R2
                upd_d = 1'b1;
              end
              default: on_d = on_q;
            endcase
          end
          DCS_CMD_DAC_DATA: if (nb_q >= 3'd4) begin
            code_d = wr_word[DCS_CODE_MSB -: RES]; // R5 R7 R8
            upd_d = 1'b1;
          end
          DCS_CMD_MARGIN_HIGH: if (nb_q >= 3'd4) mh_d = wr_word[DCS_CODE_MSB -: 8];
          DCS_CMD_MARGIN_LOW: if (nb_q >= 3'd4) ml_d = wr_word[DCS_CODE_MSB -: 8];
          DCS_CMD_GEN_CONFIG: if (nb_q >= 3'd4) cfg_d = wr_word; // R9 R10
          default: cfg_d = cfg_q;
        endcase
      end
      st_d = bus_start ? DCS_ST_RX : DCS_ST_IDLE;
      cnt_d = 4'h0;
      nb_d = 3'd0;
      rw_d = bus_start ? 1'b0 : rw_q;
      drv_d = 1'b0;
    end else begin
      case (st_q)
        DCS_ST_RX: begin
          if (scl_rise && cnt_q < 4'd8) begin
            sh_d = {sh_q[6:0], sda_s2_q};
            cnt_d = cnt_q + 4'd1;
          end else if (scl_fall && cnt_q == 4'd8) begin
            cnt_d = 4'h0;
            st_d = DCS_ST_ACK;
            drv_d = 1'b1;
            if (nb_q == 3'd0) begin
              rw_d = sh_q[0];
              txi_d = 1'b0;
              if (sh_q[7:1] != DCS_BUS_ADDR) begin
                st_d = DCS_ST_IDLE;
                drv_d = 1'b0;
              end
            end else if (nb_q == 3'd1) begin
              ptr_d = sh_q;
            end else if (nb_q == 3'd2) begin
              b2_d = sh_q;
            end else begin
              b3_d = sh_q;
            end
          end
        end
        DCS_ST_ACK: if (scl_fall) begin
          nb_d = (nb_q == 3'd7) ? nb_q : nb_q + 3'd1;
          if (rw_q) begin
            st_d = DCS_ST_TX;
            drv_d = ~tx_byte[7];
          end else begin
            st_d = DCS_ST_RX;
            drv_d = 1'b0;
          end
        end
        DCS_ST_TX: if (scl_fall) begin
          if (cnt_q == 4'd7) begin
            cnt_d = 4'h0;
            drv_d = 1'b0;
            st_d = DCS_ST_TXACK;
          end else begin
            cnt_d = cnt_q + 4'd1;
            drv_d = ~tx_byte[3'(6 - cnt_q)];
          end
        end
        DCS_ST_TXACK: begin
          if (scl_rise) begin
            if (sda_s2_q) st_d = DCS_ST_IDLE;
            else txi_d = ~txi_q;
          end else if (scl_fall) begin
            st_d = DCS_ST_TX;
            drv_d = ~tx_byte[7];
          end
        end
        default: st_d = st_q;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q <= DCS_ST_LOAD;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      b2_q <= 8'h00;
      b3_q <= 8'h00;
      cnt_q <= 4'h0;
      nb_q <= 3'd0;
      rw_q <= 1'b0;
      drv_q <= 1'b0;
      txi_q <= 1'b0;
      code_q <= '0;
      mh_q <= 8'h00;
      ml_q <= 8'h00;
      cfg_q <= DCS_CONFIG_RESET; // R4 R9
      on_q <= 1'b1;
      upd_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      b2_q <= b2_d;
      b3_q <= b3_d;
      cnt_q <= cnt_d;
      nb_q <= nb_d;
      rw_q <= rw_d;
      drv_q <= drv_d;
      txi_q <= txi_d;
      code_q <= code_d;
      mh_q <= mh_d;
      ml_q <= ml_d;
      cfg_q <= cfg_d;
      on_q <= on_d;
      upd_q <= upd_d;
    end
  end

  // open-drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = drv_q;
  assign dac_code = code_q; // R5 R7
  assign output_powerdown_select = cfg_q[DCS_PDN_LSB +: 2]; // R4 R10
  assign out_enable = on_q && (cfg_q[DCS_PDN_LSB +: 2] == DCS_PDN_ACTIVE); // R2
  assign ref_internal_en = cfg_q[DCS_REF_EN_BIT]; // R6 R9
  assign gain_span = cfg_q[DCS_SPAN_LSB +: 2];
  assign code_update = upd_q; // R8
  assign nvm_loading = (st_q == DCS_ST_LOAD); // R3
endmodule
`default_nettype wire

// [shared/dcs_pkg.sv]
// constants for the converter code and startup control block
// assumes one 100 MHz clock and a register word of 16 bits
package dcs_pkg;
  localparam int unsigned DCS_WORD_W = 16;
  // command pointers
  localparam logic [7:0] DCS_CMD_OPERATION = 8'h01;
  localparam logic [7:0] DCS_CMD_DAC_DATA = 8'h10;
  localparam logic [7:0] DCS_CMD_MARGIN_HIGH = 8'h25;
  localparam logic [7:0] DCS_CMD_MARGIN_LOW = 8'h26;
  localparam logic [7:0] DCS_CMD_GEN_CONFIG = 8'hD1;
  // operation byte values
  localparam logic [7:0] DCS_OP_OFF = 8'h00;
  localparam logic [7:0] DCS_OP_ON = 8'h80;
  localparam logic [7:0] DCS_OP_MARGIN_LOW = 8'h94;
  localparam logic [7:0] DCS_OP_MARGIN_HIGH = 8'hA4;
  // general config field positions
  localparam int unsigned DCS_PDN_LSB = 3;
  localparam int unsigned DCS_REF_EN_BIT = 2;
  localparam int unsigned DCS_SPAN_LSB = 0;
  // code field msb in data and margin words
  localparam int unsigned DCS_CODE_MSB = 11;
  localparam int unsigned DCS_MARGIN_LSB = 4;
  // output power-down selections
  localparam logic [1:0] DCS_PDN_ACTIVE = 2'h0;
  localparam logic [1:0] DCS_PDN_RES_GND = 2'h1;
  localparam logic [1:0] DCS_PDN_HIZ = 2'h2;
  // factory config: output high impedance, internal reference off
  localparam logic [15:0] DCS_CONFIG_RESET = 16'h0010;
  // device bus address, arbitrary value
  localparam logic [6:0] DCS_BUS_ADDR = 7'h48;
  // link rate ceilings in kbps and the fastest bit time in cycles
  localparam int unsigned DCS_CLK_MHZ = 100;
  localparam int unsigned DCS_STD_KBPS = 100;
  localparam int unsigned DCS_FAST_KBPS = 400;
  localparam int unsigned DCS_FASTP_KBPS = 1000;
  localparam int unsigned DCS_MIN_BIT_CYC = DCS_CLK_MHZ * 1000 / DCS_FASTP_KBPS;
  typedef enum logic [2:0] {
    DCS_ST_LOAD = 3'b000,
    DCS_ST_IDLE = 3'b001,
    DCS_ST_RX = 3'b010,
    DCS_ST_ACK = 3'b011,
    DCS_ST_TX = 3'b100,
    DCS_ST_TXACK = 3'b101
  } dcs_state_t;
endpackage

// [sim/dcs_core_checker.sv]
// assertions on the ports of the converter control block
// assumes a bind into dcs_core and the single mclk domain
`timescale 1ns/1ps
`default_nettype none
module dcs_core_checker #(
  parameter int unsigned RES = 10
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic nvm_valid,
  input wire logic [15:0] nvm_dac_data,
  input wire logic [15:0] nvm_config,
  input wire logic [RES-1:0] dac_code,
  input wire logic [1:0] output_powerdown_select,
  input wire logic out_enable,
  input wire logic ref_internal_en,
  input wire logic sda_oe,
  input wire logic nvm_loading
);
  import dcs_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_take;
    nvm_loading && nvm_valid;
  endsequence
  a_load_code: assert property (s_take |=> dac_code == $past(nvm_dac_data[11:12-RES]))
    else $error("code not loaded");
  a_load_pdn: assert property (s_take |=> output_powerdown_select == $past(nvm_config[4:3]))
    else $error("pdn not loaded");
  a_load_done: assert property (s_take |=> !nvm_loading)
    else $error("load not ended");
  a_reset_state: assert property (disable iff (1'b0) sys_rst |=> nvm_loading && !out_enable
    && !ref_internal_en && output_powerdown_select == DCS_PDN_HIZ)
    else $error("bad reset state");
  a_quiet_load: assert property (nvm_loading |-> !sda_oe)
    else $error("ack while loading");
  a_enable_pdn: assert property (out_enable |-> output_powerdown_select == DCS_PDN_ACTIVE)
    else $error("enabled while powered down");
  a_pdn_commit: assert property ($changed(output_powerdown_select) |-> $past(nvm_loading)
    || scl_in)
    else $error("pdn changed mid frame");
  a_code_commit: assert property ($changed(dac_code) |-> $past(nvm_loading) || scl_in)
    else $error("code changed mid frame");
endmodule
bind dcs_core dcs_core_checker #(.RES(RES)) u_chk (.mclk, .sys_rst, .scl_in, .nvm_valid,
  .nvm_dac_data, .nvm_config, .dac_code, .output_powerdown_select, .out_enable,
  .ref_internal_en, .sda_oe, .nvm_loading);
`default_nettype wire

// [sim/dcs_i2c_host.sv]
// serial link controller model
// assumes a pull-up on sda; q is a quarter bit time in mclk cycles
`timescale 1ns/1ps
`default_nettype none
module dcs_i2c_host (
  // clock
  input wire logic mclk,
  // link lines
  input wire logic sda,
  output var logic scl,
  output var logic sda_low
);
  int q = 25;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // data moves while scl is low, never faster than q allows
  task automatic bt(input logic b, output logic r);
    sda_low <= !b;
    tk(q);
    scl <= 1'b1;
    tk(q);
    r = sda;
    tk(q);
    scl <= 1'b0;
    tk(q);
  endtask
  task automatic by(input logic [7:0] d, output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--) bt(d[i], r);
    bt(1'b1, r);
    ak = !r;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] w,
    input logic two, output logic ok);
    logic k1, k2, k3, k4;
    tk(1);
    sda_low <= 1'b1;
    tk(2*q);
    scl <= 1'b0;
    tk(q);
    by({a, 1'b0}, k1);
    by(p, k2);
    by(two ? w[15:8] : w[7:0], k3);
    k4 = 1'b1;
    if (two) by(w[7:0], k4);
    ok = k1 & k2 & k3 & k4;
  endtask
  // word read: pointer write, repeated start, msb acked, lsb refused
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [15:0] w,
    output logic ok);
    logic k1, k2, k3, r;
    tk(1);
    sda_low <= 1'b1;
    tk(2*q);
    scl <= 1'b0;
    tk(q);
    by({a, 1'b0}, k1);
    by(p, k2);
    sda_low <= 1'b0;
    tk(q);
    scl <= 1'b1;
    tk(2*q);
    sda_low <= 1'b1;
    tk(2*q);
    scl <= 1'b0;
    tk(q);
    by({a, 1'b1}, k3);
    for (int i = 15; i >= 8; i--) bt(1'b1, w[i]);
    bt(1'b0, r);
    for (int i = 7; i >= 0; i--) bt(1'b1, w[i]);
    bt(1'b1, r);
    ok = k1 & k2 & k3;
  endtask
  task automatic sp();
    tk(1);
    sda_low <= 1'b1;
    tk(q);
    scl <= 1'b1;
    tk(2*q);
    sda_low <= 1'b0;
    tk(4*q);
  endtask
endmodule
`default_nettype wire

// [sim/dcs_core_bench.sv]
// self-checking bench for the converter control block
// assumes the controller model on the link and a pull-up on sda
`timescale 1ns/1ps
`default_nettype none
module dcs_core_bench;
  import dcs_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic nvm_valid = 1'b0;
  logic [15:0] nvm_dac_data = 16'h0000, nvm_config = 16'h0000;
  logic [15:0] nvm_margin_high = 16'h0000, nvm_margin_low = 16'h0000;
  logic [9:0] dac_code, cur;
  logic [1:0] output_powerdown_select, gain_span;
  logic sda_out, code_update;
  int upd_cnt = 0;
  logic scl_in, h_low, sda_oe, out_enable, ref_internal_en, nvm_loading;
  int miscompares = 0, checks_done = 0;
  wire logic sda_in = !(h_low || sda_oe);
  always #5 mclk = ~mclk;
  dcs_core i_dut (.mclk, .sys_rst, .scl_in, .sda_in, .sda_out(sda_out), .sda_oe, .nvm_valid,
    .nvm_dac_data, .nvm_config, .nvm_margin_high, .nvm_margin_low, .dac_code,
    .output_powerdown_select, .out_enable, .ref_internal_en, .gain_span(gain_span),
    .code_update(code_update), .nvm_loading);
  // counts commit pulses
  always @(posedge mclk) if (code_update) upd_cnt <= upd_cnt + 1;
  dcs_i2c_host i_host (.mclk, .sda(sda_in), .scl(scl_in), .sda_low(h_low));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, s, e);
    end
  endtask
  task automatic close_out();
    if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic boot(input logic [15:0] d, input logic [15:0] c);
    @(posedge mclk);
    sys_rst <= 1'b1;
    nvm_valid <= 1'b0;
    nvm_dac_data <= d;
    nvm_config <= c;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    #1 chk(nvm_loading, 1'b1);
    chk(output_powerdown_select, DCS_PDN_HIZ);
    chk(ref_internal_en, 1'b0);
    chk(sda_out, 1'b0);
    @(posedge mclk);
    nvm_valid <= 1'b1;
    repeat (6) @(posedge mclk);
    #1 chk(dac_code, d[11:2]);
    chk(output_powerdown_select, c[4:3]);
    chk(gain_span, c[1:0]);
    cur = d[11:2];
  endtask
  task automatic put(input logic [7:0] p, input logic [15:0] w, input logic two);
    logic ok;
    i_host.wr(DCS_BUS_ADDR, p, w, two, ok);
    i_host.sp();
    #1 chk(ok, 1'b1);
  endtask
  task automatic wcode(input int qq, input logic [9:0] v);
    logic ok;
    int u;
    i_host.q = qq;
    i_host.wr(DCS_BUS_ADDR, DCS_CMD_DAC_DATA, {4'h0, v, 2'b00}, 1'b1, ok);
    #1 chk(ok, 1'b1);
    chk(dac_code, cur);
    u = upd_cnt;
    i_host.sp();
    #1 chk(dac_code, v);
    chk(16'(upd_cnt - u), 16'h0001);
    cur = v;
  endtask
  task automatic t_bad();
    logic ok;
    int u;
    u = upd_cnt;
    i_host.wr(DCS_BUS_ADDR ^ 7'h01, DCS_CMD_DAC_DATA, 16'h0000, 1'b1, ok);
    i_host.sp();
    #1 chk(ok, 1'b0);
    chk(dac_code, cur);
    chk(16'(upd_cnt - u), 16'h0000);
  endtask
  task automatic t_read();
    logic ok;
    logic [15:0] w;
    i_host.rd(DCS_BUS_ADDR, DCS_CMD_DAC_DATA, w, ok);
    i_host.sp();
    #1 chk(ok, 1'b1);
    chk(w, 16'h0120);
  endtask
  task automatic t_ops();
    put(DCS_CMD_GEN_CONFIG, 16'h0000, 1'b1);
    chk(output_powerdown_select, DCS_PDN_ACTIVE);
    put(DCS_CMD_MARGIN_HIGH, 16'h0AB0, 1'b1);
    put(DCS_CMD_MARGIN_LOW, 16'h0120, 1'b1);
    put(DCS_CMD_OPERATION, DCS_OP_OFF, 1'b0);
    chk(out_enable, 1'b0);
    put(DCS_CMD_OPERATION, DCS_OP_ON, 1'b0);
    chk(out_enable, 1'b1);
    put(DCS_CMD_OPERATION, DCS_OP_MARGIN_HIGH, 1'b0);
    chk(dac_code, 10'h2AC);
    put(DCS_CMD_OPERATION, DCS_OP_MARGIN_LOW, 1'b0);
    chk(dac_code, 10'h048);
    put(DCS_CMD_GEN_CONFIG, 16'h0006, 1'b1);
    chk(ref_internal_en, 1'b1);
    chk(gain_span, 2'h2);
  endtask
  initial begin
    boot(16'h0A5C, 16'h000B);
    wcode(250, 10'h3FF);
    wcode(65, 10'h000);
    wcode(25, 10'h155);
    wcode(25, 10'h2AA);
    t_bad();
    t_ops();
    t_read();
    boot(16'h0000, 16'h0010);
    close_out();
  end
  initial begin
    #970000;
    miscompares++;
    close_out();
  end
endmodule
`default_nettype wire
